//--- logic/bscan_pkg.sv
/*
  Shared constants and types for the boundary-scan test port:
  chain layout, instruction codes, TAP state encoding, register map.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package bscan_pkg;

   // =====================================================
   // chain layout
   localparam int NUM_PINS  = 4;
   localparam int GROUP_W   = 3;
   localparam int BSR_LEN   = NUM_PINS * GROUP_W;
   localparam int CELL_OUT  = 0;
   localparam int CELL_OE   = 1;
   localparam int CELL_IN   = 2;
   localparam int ID_W      = 32;

   // =====================================================
   // instructions
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_EXTEST   = 4'h0;
   localparam logic [IR_W-1:0] IR_SAMPLE   = 4'h1;
   localparam logic [IR_W-1:0] IR_IDCODE   = 4'h6;
   localparam logic [IR_W-1:0] IR_USERCODE = 4'h7;
   localparam logic [IR_W-1:0] IR_BYPASS   = 4'hF;
   localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;

   // identification value, arbitrary
   localparam logic [ID_W-1:0] DEVICE_ID = 32'h0A5C_3001;

   // =====================================================
   // TAP states
   typedef enum logic [3:0] {
      ST_RESET      = 4'h0,
      ST_IDLE       = 4'h1,
      ST_SEL_DR     = 4'h3,
      ST_CAPTURE_DR = 4'h2,
      ST_SHIFT_DR   = 4'h6,
      ST_EXIT1_DR   = 4'h7,
      ST_PAUSE_DR   = 4'h5,
      ST_EXIT2_DR   = 4'h4,
      ST_UPDATE_DR  = 4'hC,
      ST_SEL_IR     = 4'hD,
      ST_CAPTURE_IR = 4'hF,
      ST_SHIFT_IR   = 4'hE,
      ST_EXIT1_IR   = 4'hA,
      ST_PAUSE_IR   = 4'hB,
      ST_EXIT2_IR   = 4'h9,
      ST_UPDATE_IR  = 4'h8
   } tap_state_e;

   // =====================================================
   // register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_CONTROL  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_USERCODE = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_IDCODE   = 8'h0C;
   localparam int CTRL_ENABLE   = 0;
   localparam int STAT_STATE_LO = 0;
   localparam int STAT_IR_LO    = 4;
   localparam int STAT_EXTEST   = 8;
   localparam logic        ENABLE_RESET   = 1'b1;
   localparam logic [31:0] USERCODE_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

//--- logic/tap_state_if.sv
/*
  Carries the TAP controller state from the sequencer to the port logic.
  Assumes both ends run on the same ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

interface tap_state_if;
   import bscan_pkg::*;

   tap_state_e state;

   modport ctrl (output state);
   modport user (input  state);
endinterface

`default_nettype wire

//--- logic/tap_sequencer.sv
/*
  Sixteen-state TAP controller, stepped on each synchronised test-clock
  rising edge. Assumes tck_rise, tms and hold_reset are already
  synchronised to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module tap_sequencer
   import bscan_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic tck_rise,
   input  wire logic tms,
   input  wire logic hold_reset,
   tap_state_if.ctrl tap
);

   tap_state_e next_state;

   // =====================================================
   // next state
   always_comb
   begin
      next_state = tap.state;
      case (tap.state)
         ST_RESET:      next_state = tms ? ST_RESET     : ST_IDLE;
         ST_IDLE:       next_state = tms ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_DR:     next_state = tms ? ST_SEL_IR    : ST_CAPTURE_DR;
         ST_CAPTURE_DR: next_state = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_SHIFT_DR:   next_state = tms ? ST_EXIT1_DR  : ST_SHIFT_DR;
         ST_EXIT1_DR:   next_state = tms ? ST_UPDATE_DR : ST_PAUSE_DR;
         ST_PAUSE_DR:   next_state = tms ? ST_EXIT2_DR  : ST_PAUSE_DR;
         ST_EXIT2_DR:   next_state = tms ? ST_UPDATE_DR : ST_SHIFT_DR;
         ST_UPDATE_DR:  next_state = tms ? ST_SEL_DR    : ST_IDLE;
         ST_SEL_IR:     next_state = tms ? ST_RESET     : ST_CAPTURE_IR;
         ST_CAPTURE_IR: next_state = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_SHIFT_IR:   next_state = tms ? ST_EXIT1_IR  : ST_SHIFT_IR;
         ST_EXIT1_IR:   next_state = tms ? ST_UPDATE_IR : ST_PAUSE_IR;
         ST_PAUSE_IR:   next_state = tms ? ST_EXIT2_IR  : ST_PAUSE_IR;
         ST_EXIT2_IR:   next_state = tms ? ST_UPDATE_IR : ST_SHIFT_IR;
         ST_UPDATE_IR:  next_state = tms ? ST_SEL_DR    : ST_IDLE;
         default:       next_state = ST_RESET;
      endcase
   end

   // =====================================================
   // state register, starts in reset after power-up
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || hold_reset)
         tap.state <= ST_RESET;
      else if (tck_rise)
         tap.state <= next_state;
   end

endmodule

`default_nettype wire

//--- logic/boundary_scan_port.sv
/*
  Boundary-scan test port: TAP pins sampled by ref_clk, boundary chain
  over NUM_PINS I/O cell groups, bypass, identity and user-code paths,
  and an APB slave for enable, user signature and status.
  Assumes tck/tms/tdi/trst_n and pad inputs are asynchronous to ref_clk,
  core and APB signals are synchronous, and tck is far slower than ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module boundary_scan_port
   import bscan_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   input  wire logic                tck,
   input  wire logic                tms,
   input  wire logic                tdi,
   input  wire logic                trst_n,
   output logic                     tdo,
   output logic                     tdo_oe,
   input  wire logic [NUM_PINS-1:0] core_out,
   input  wire logic [NUM_PINS-1:0] core_oe,
   output logic      [NUM_PINS-1:0] core_in,
   input  wire logic [NUM_PINS-1:0] pad_in,
   output logic      [NUM_PINS-1:0] pad_out,
   output logic      [NUM_PINS-1:0] pad_oe,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr
);

   // =====================================================
   // pin synchronisers
   logic                tck_s1;
   logic                tck_s2;
   logic                tck_s3;
   logic                tms_s1;
   logic                tms_s2;
   logic                tdi_s1;
   logic                tdi_s2;
   logic                trst_s1;
   logic                trst_s2;
   logic [NUM_PINS-1:0] pad_s1;
   logic [NUM_PINS-1:0] pad_s2;

   // dedicated pins: never routed to core logic
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         tck_s1  <= 1'b0;
         tck_s2  <= 1'b0;
         tck_s3  <= 1'b0;
         tms_s1  <= 1'b1;
         tms_s2  <= 1'b1;
         tdi_s1  <= 1'b1;
         tdi_s2  <= 1'b1;
         trst_s1 <= 1'b0;
         trst_s2 <= 1'b0;
      end
      else
      begin
         tck_s1  <= tck;
         tck_s2  <= tck_s1;
         tck_s3  <= tck_s2;
         tms_s1  <= tms;
         tms_s2  <= tms_s1;
         tdi_s1  <= tdi;
         tdi_s2  <= tdi_s1;
         trst_s1 <= trst_n;
         trst_s2 <= trst_s1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      pad_s1 <= pad_in;
      pad_s2 <= pad_s1;
   end

   wire tck_rise = tck_s2 & ~tck_s3;
   wire tck_fall = ~tck_s2 & tck_s3;

   // =====================================================
   // software registers
   logic              test_enable;
   logic [ID_W-1:0]   user_signature;

   wire hold_reset = ~trst_s2 | ~test_enable;

   // =====================================================
   // TAP controller
   tap_state_if tap ();

   tap_sequencer u_tap (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .tck_rise   (tck_rise),
      .tms        (tms_s2),
      .hold_reset (hold_reset),
      .tap        (tap.ctrl)
   );

   wire st_capture_dr = tap.state == ST_CAPTURE_DR;
   wire st_shift_dr   = tap.state == ST_SHIFT_DR;
   wire st_update_dr  = tap.state == ST_UPDATE_DR;
   wire st_capture_ir = tap.state == ST_CAPTURE_IR;
   wire st_shift_ir   = tap.state == ST_SHIFT_IR;
   wire st_update_ir  = tap.state == ST_UPDATE_IR;
   wire st_reset      = tap.state == ST_RESET;

   // data-register clock strobes
   wire dr_capture_clk = tck_rise & st_capture_dr;
   wire dr_shift_clk   = tck_rise & st_shift_dr;
   wire dr_update_clk  = tck_fall & st_update_dr;

   // =====================================================
   // instruction register and decode
   logic [IR_W-1:0] ir;
   logic [IR_W-1:0] ir_shift;

   wire sel_extest = ir == IR_EXTEST;
   wire sel_bsr    = sel_extest | (ir == IR_SAMPLE);
   wire sel_id     = ir == IR_IDCODE;
   wire sel_user   = ir == IR_USERCODE;
   // all-ones and every unimplemented code fall to bypass
   wire sel_bypass = ~(sel_bsr | sel_id | sel_user);

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         ir_shift <= IR_CAPTURE;
      else if (tck_rise && st_capture_ir)
         ir_shift <= IR_CAPTURE;
      else if (tck_rise && st_shift_ir)
         ir_shift <= {tdi_s2, ir_shift[IR_W-1:1]};
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || st_reset)
         ir <= IR_IDCODE;
      else if (tck_fall && st_update_ir)
         ir <= ir_shift;
   end

   // =====================================================
   // boundary chain
   logic [BSR_LEN-1:0]  bsr;
   logic [BSR_LEN-1:0]  upd;
   logic [BSR_LEN-1:0]  cap_vec;
   logic [NUM_PINS-1:0] upd_out;
   logic [NUM_PINS-1:0] upd_oe;
   logic [NUM_PINS-1:0] upd_in;

   for (genvar i = 0; i < NUM_PINS; i++)
   begin : g_cell
      // capture: pin, enable (one = off), driven value
      assign cap_vec[i*GROUP_W+CELL_IN]  = pad_s2[i];
      assign cap_vec[i*GROUP_W+CELL_OE]  = ~pad_oe[i];
      assign cap_vec[i*GROUP_W+CELL_OUT] = pad_out[i];
      assign upd_out[i] = upd[i*GROUP_W+CELL_OUT];
      assign upd_oe[i]  = upd[i*GROUP_W+CELL_OE];
      assign upd_in[i]  = upd[i*GROUP_W+CELL_IN];
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         bsr <= '0;
      else if (dr_capture_clk && sel_bsr)
         bsr <= cap_vec;
      else if (dr_shift_clk && sel_bsr)
         bsr <= {tdi_s2, bsr[BSR_LEN-1:1]};
   end

   // update registers move only on the update strobe
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         upd <= '0;
      else if (dr_update_clk && sel_bsr)
         upd <= bsr;
   end

   // =====================================================
   // pin and core paths
   logic [NUM_PINS-1:0] next_pad_out;
   logic [NUM_PINS-1:0] next_pad_oe;
   logic [NUM_PINS-1:0] next_core_in;

   // extest selects update data as soon as the instruction is in ir
   assign next_pad_out = sel_extest ? upd_out : core_out;
   assign next_pad_oe  = sel_extest ? ~upd_oe : core_oe;
   assign next_core_in = sel_extest ? upd_in  : pad_s2;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pad_out <= '0;
         pad_oe  <= '0;
         core_in <= '0;
      end
      else
      begin
         pad_out <= next_pad_out;
         pad_oe  <= next_pad_oe;
         core_in <= next_core_in;
      end
   end

   // =====================================================
   // bypass and identity registers
   logic            bypass_bit;
   logic [ID_W-1:0] id_shift;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         bypass_bit <= 1'b0;
      else if (dr_capture_clk && sel_bypass)
         bypass_bit <= 1'b0;
      else if (dr_shift_clk && sel_bypass)
         bypass_bit <= tdi_s2;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         id_shift <= '0;
      else if (dr_capture_clk && sel_id)
         id_shift <= DEVICE_ID;
      else if (dr_capture_clk && sel_user)
         id_shift <= user_signature;
      else if (dr_shift_clk && (sel_id || sel_user))
         id_shift <= {tdi_s2, id_shift[ID_W-1:1]};
   end

   // =====================================================
   // data-out, changes on the falling test-clock edge
   wire dr_bit = sel_bsr ? bsr[0] :
                 (sel_id | sel_user) ? id_shift[0] : bypass_bit;
   wire next_tdo    = st_shift_ir ? ir_shift[0] : dr_bit;
   wire next_tdo_oe = st_shift_ir | st_shift_dr;

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else if (tck_fall)
      begin
         tdo    <= next_tdo;
         tdo_oe <= next_tdo_oe;
      end
   end

   // =====================================================
   // APB slave
   wire apb_access = psel & penable & ~pready;
   wire apb_wr     = apb_access & pwrite;
   wire apb_rd     = apb_access & ~pwrite;
   wire hit_ctrl   = paddr == OFF_CONTROL;
   wire hit_user   = paddr == OFF_USERCODE;
   wire hit_stat   = paddr == OFF_STATUS;
   wire hit_id     = paddr == OFF_IDCODE;
   wire hit_any    = hit_ctrl | hit_user | hit_stat | hit_id;

   logic [31:0] status_word;
   logic [31:0] read_word;

   always_comb
   begin
      status_word = '0;
      status_word[STAT_STATE_LO +: 4]    = tap.state;
      status_word[STAT_IR_LO +: IR_W]    = ir;
      status_word[STAT_EXTEST]           = sel_extest;
   end

   assign read_word = hit_ctrl ? {31'h0, test_enable} :
                      hit_user ? user_signature :
                      hit_stat ? status_word :
                      hit_id   ? DEVICE_ID : 32'h0000_0000;

   // only the bus writes the enable; the test port has no path to it
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         test_enable    <= ENABLE_RESET;
         user_signature <= USERCODE_RESET;
      end
      else if (apb_wr && hit_ctrl)
         test_enable    <= pwdata[CTRL_ENABLE];
      else if (apb_wr && hit_user)
         user_signature <= pwdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= apb_access;
         pslverr <= apb_access & ~hit_any;
         prdata  <= apb_rd ? read_word : 32'h0000_0000;
      end
   end

endmodule

`default_nettype wire

//--- tb/boundary_scan_port_assertions.sv
/*
  Checker on the top ports of the boundary-scan port.
  Assumes tck is far slower than ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module boundary_scan_port_checker
   import bscan_pkg::*;
(
   input wire logic              ref_clk,
   input wire logic              sys_rst,
   input wire logic              tck,
   input wire logic              tdo,
   input wire logic              tdo_oe,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [31:0]       prdata
);
   // ==================================================
   // helpers
   logic       tck_q;
   logic [3:0] since_fall;
   wire        mapped = paddr inside {OFF_CONTROL, OFF_USERCODE, OFF_STATUS, OFF_IDCODE};

   always_ff @(posedge ref_clk)
   begin
      tck_q <= tck;
      if (sys_rst)
         since_fall <= 4'hF;
      else if (tck_q && !tck)
         since_fall <= 4'h0;
      else if (since_fall != 4'hF)
         since_fall <= since_fall + 4'h1;
   end

   // ==================================================
   // properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_access;
      psel && penable && !pready;
   endsequence
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   property p_one_wait;
      s_access |=> s_answer;
   endproperty
   property p_no_early;
      psel && !penable |=> !pready;
   endproperty
   property p_refused;
      s_access and !mapped |=> pready && pslverr && prdata == 32'h0;
   endproperty
   property p_accepted;
      s_access and mapped |=> !pslverr;
   endproperty
   property p_err_with_ready;
      pslverr |-> pready;
   endproperty
   property p_tdo_edge;
      $changed(tdo) |-> since_fall <= 4'h6;
   endproperty
   property p_oe_edge;
      $changed(tdo_oe) |-> since_fall <= 4'h6;
   endproperty
   property p_quiet_reset;
      $fell(sys_rst) |-> !tdo_oe && !pready && tdo == 1'b0;
   endproperty

   a_one_wait:       assert property (p_one_wait) else $error("answer not after one wait");
   a_no_early:       assert property (p_no_early) else $error("answer in setup cycle");
   a_refused:        assert property (p_refused) else $error("unmapped access not refused");
   a_accepted:       assert property (p_accepted) else $error("mapped access refused");
   a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
   a_tdo_edge:       assert property (p_tdo_edge) else $error("tdo moved off falling edge");
   a_oe_edge:        assert property (p_oe_edge) else $error("tdo_oe moved off falling edge");
   a_quiet_reset:    assert property (p_quiet_reset) else $error("outputs busy after reset");
endmodule

bind boundary_scan_port boundary_scan_port_checker u_chk (
   .ref_clk (ref_clk),
   .sys_rst (sys_rst),
   .tck     (tck),
   .tdo     (tdo),
   .tdo_oe  (tdo_oe),
   .psel    (psel),
   .penable (penable),
   .paddr   (paddr),
   .pready  (pready),
   .pslverr (pslverr),
   .prdata  (prdata)
);

`default_nettype wire

//--- tb/jtag_ctrl_model.sv
/*
  Behavioural test controller driving tck, tms and tdi.
  Assumes scans start from run-test/idle; tck stands low between scans.
*/
`timescale 1ns/100ps
`default_nettype none

module jtag_ctrl_model (
   input  wire logic ref_clk,
   input  wire logic tdo,
   input  wire logic tdo_oe,
   output logic      tck,
   output logic      tms,
   output logic      tdi
);
   logic oe_seen;
   logic config_request_n;

   // parked levels keep the port inactive
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      oe_seen = 1'b0;
      config_request_n = 1'b0;
   end

   // one 160 ns tck pulse; tdo read just before the rise
   task automatic tick(input logic m, input logic d, output logic q);
      @(posedge ref_clk);
      tms <= m;
      tdi <= d;
      repeat (15) @(posedge ref_clk);
      // released tdo has no pull, so it reads as the wrong level
      q = tdo_oe ? tdo : ~tdo;
      oe_seen = oe_seen | tdo_oe;
      tck <= 1'b1;
      repeat (16) @(posedge ref_clk);
      tck <= 1'b0;
   endtask

   task automatic reset_tap();
      logic q;
      repeat (5) tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
   endtask

   // idle to shift, n bits lsb first, then update and idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      tick(1'b1, 1'b1, q);
      if (ir)
         tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
      tick(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++)
      begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
   endtask
endmodule

`default_nettype wire

//--- tb/boundary_scan_port_test.sv
/*
  Self-checking bench for the boundary-scan port.
  Assumes the checker is bound and the controller model drives the link.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end

module boundary_scan_port_test;
   import bscan_pkg::*;

   logic              ref_clk  = 1'b0;
   logic              sys_rst  = 1'b1;
   logic              trst_n   = 1'b1;
   logic [3:0]        core_out = 4'hA;
   logic [3:0]        core_oe  = 4'hF;
   logic [3:0]        pad_in   = 4'h5;
   logic              psel     = 1'b0;
   logic              penable  = 1'b0;
   logic              pwrite   = 1'b0;
   logic [ADDR_W-1:0] paddr    = '0;
   logic [31:0]       pwdata   = '0;
   wire               tck, tms, tdi, tdo, tdo_oe, pready, pslverr;
   wire  [3:0]        core_in, pad_out, pad_oe;
   wire  [31:0]       prdata;
   int                n_checks   = 0;
   int                n_mismatch = 0;
   int                cyc        = 0;
   logic [31:0]       rd, d;
   logic              er;

   always #2.5 ref_clk = ~ref_clk;

   boundary_scan_port dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
      .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
      .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   jtag_ctrl_model m (.ref_clk(ref_clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi));

   // ==================================================
   // shared tasks
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
         @(posedge ref_clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check_pads(input logic [11:0] p);
      for (int i = 0; i < NUM_PINS; i++)
      begin
         `CHK(pad_out[i], p[3*i])
         `CHK(pad_oe[i], ~p[3*i+1])
         `CHK(core_in[i], p[3*i+2])
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ==================================================
   // scenarios
   task automatic t_regs();
      apb(1'b0, OFF_CONTROL, 32'h0);
      `CHK(rd[CTRL_ENABLE], ENABLE_RESET)
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd[8:0], {1'b0, IR_IDCODE, ST_RESET})
      apb(1'b0, OFF_USERCODE, 32'h0);
      `CHK(rd, USERCODE_RESET)
      apb(1'b1, 8'h10, 32'hFFFF_FFFF);
      `CHK(er, 1'b1)
      $display("t_regs done");
   endtask

   task automatic t_id();
      m.reset_tap();
      m.oe_seen = 1'b0;
      m.scan(1'b0, 32, 32'h0, d);
      `CHK(d, DEVICE_ID)
      `CHK(m.oe_seen, 1'b1)
      `CHK(tdo_oe, 1'b0)
      $display("t_id done");
   endtask

   task automatic t_user();
      apb(1'b1, OFF_USERCODE, 32'h5AC3_0F96);
      m.scan(1'b1, 4, {28'h0, IR_USERCODE}, d);
      `CHK(d[3:0], IR_CAPTURE)
      m.scan(1'b0, 32, 32'h0, d);
      `CHK(d, 32'h5AC3_0F96)
      $display("t_user done");
   endtask

   task automatic t_bypass();
      logic [3:0] codes [2] = '{IR_BYPASS, 4'h3};
      foreach (codes[k])
      begin
         m.scan(1'b1, 4, {28'h0, codes[k]}, d);
         m.scan(1'b0, 8, 32'hB5, d);
         `CHK(d[7:0], 8'h6A)
      end
      $display("t_bypass done");
   endtask

   task automatic t_extest();
      logic [11:0] e;
      for (int i = 0; i < NUM_PINS; i++)
         e[3*i +: 3] = {pad_in[i], ~core_oe[i], core_out[i]};
      m.scan(1'b1, 4, {28'h0, IR_SAMPLE}, d);
      m.scan(1'b0, 12, 32'h6B9, d);
      `CHK(d[11:0], e)
      `CHK({pad_out, pad_oe, core_in}, {core_out, core_oe, pad_in})
      m.scan(1'b1, 4, {28'h0, IR_EXTEST}, d);
      check_pads(12'h6B9);
      pad_in <= 4'h9;
      m.scan(1'b0, 24, 32'h3C6A5F, d);
      `CHK(d[23:12], 12'hA5F)
      for (int i = 0; i < NUM_PINS; i++)
         `CHK(d[3*i+2], pad_in[i])
      check_pads(12'h3C6);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd[8:4], {1'b1, IR_EXTEST})
      apb(1'b0, OFF_CONTROL, 32'h0);
      `CHK(rd[CTRL_ENABLE], 1'b1)
      m.reset_tap();
      `CHK(pad_out, core_out)
      $display("t_extest done");
   endtask

   task automatic t_off();
      apb(1'b1, OFF_CONTROL, 32'h0);
      m.oe_seen = 1'b0;
      m.scan(1'b1, 4, {28'h0, IR_BYPASS}, d);
      `CHK(m.oe_seen, 1'b0)
      apb(1'b1, OFF_CONTROL, 32'h1);
      trst_n <= 1'b0;
      m.scan(1'b1, 4, {28'h0, IR_BYPASS}, d);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK(rd[7:0], {IR_IDCODE, ST_RESET})
      trst_n <= 1'b1;
      $display("t_off done");
   endtask

   // ==================================================
   // main sequence and timeout
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_id();
      t_user();
      t_bypass();
      t_extest();
      t_off();
      tally_and_finish();
   end
endmodule

`default_nettype wire
